/* File: pkg/aasao_pkg.sv */
/*
 * Constants, opcode classes and register map of the accumulator datapath.
 * Assumes an AXI4-Lite master with a 12-bit byte address and 32-bit data.
 */
// Overview of operation
// [RL1] Pointer add sums a signed 6-bit literal into pointer pair 0 or 1.
// [RL2] Pointer pair results wrap modulo 65536, never saturate.
// [RL3] AND with immediate goes to accumulator; only zero flag changes.
// [RL4] Add immediate goes to accumulator; carry, digit carry, zero change.
// [RL5] AND with data register goes to chosen destination; zero flag only.
// [RL6] Destination select 0 writes accumulator, 1 writes the data register.
// [RL7] Add with data register goes to chosen destination; C, DC, Z change.
// [RL8] Arithmetic shift right moves bit 0 into carry; carry and zero change.
// [RL9] Arithmetic shift keeps the original bit 7 as the result sign.
// [RL10] Add with carry sums accumulator, data register and carry flag.
// [RL11] Pointer add takes one cycle, encoded 11 0001 0nkk kkkk.
// [RL12] Zero marks an all-zero result; carry from bit 7, digit from bit 3.
// [RL13] Data register address is 7 bits; pointer add leaves flags alone.
package aasao_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int          ADDR_W      = 12;
    localparam logic [11:0] OFS_INSTR   = 12'h000;
    localparam logic [11:0] OFS_ACCUM   = 12'h004;
    localparam logic [11:0] OFS_STATUS  = 12'h008;
    localparam logic [11:0] OFS_PTR0    = 12'h00c;
    localparam logic [11:0] OFS_PTR1    = 12'h010;
    localparam logic [11:0] OFS_DMEM    = 12'h200;
    localparam int          DMEM_LSB    = 9;

    // ------------------------------------------------------------------
    // Status fields and reset values
    // ------------------------------------------------------------------
    localparam int          ST_C        = 0;
    localparam int          ST_DC       = 1;
    localparam int          ST_Z        = 2;
    localparam int          ST_UNK      = 3;
    localparam logic [13:0] RST_INSTR   = 14'h0000;
    localparam logic [7:0]  RST_ACCUM   = 8'h00;
    localparam logic [3:0]  RST_STATUS  = 4'h0;
    localparam logic [15:0] RST_PTR     = 16'h0000;

    // ------------------------------------------------------------------
    // Opcodes, upper bits of the 14-bit instruction word
    // ------------------------------------------------------------------
    localparam logic [5:0]  OP_ADDI     = 6'h3e;
    localparam logic [5:0]  OP_ANDI     = 6'h39;
    localparam logic [5:0]  OP_ANDR     = 6'h05;
    localparam logic [5:0]  OP_ADDR     = 6'h07;
    localparam logic [5:0]  OP_ASR      = 6'h37;
    localparam logic [5:0]  OP_ADDC     = 6'h3d;
    localparam logic [6:0]  OP_PTR      = 7'h62;

    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        OPK_NONE = 3'h0,
        OPK_ADDI = 3'h1,
        OPK_ANDI = 3'h2,
        OPK_ANDR = 3'h3,
        OPK_ADDR = 3'h4,
        OPK_ASR  = 3'h5,
        OPK_ADDC = 3'h6,
        OPK_PTR  = 3'h7
    } aasao_op_e;

endpackage : aasao_pkg

/* File: hdl/aasao_add8.sv */
/*
 * Byte adder with carry in, carry out of the top bit and of bit 3.
 * Purely combinational; the caller registers the results.
 */
`timescale 1ns/1ps
module aasao_add8 #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] a,
    input  wire logic [W-1:0] b,
    input  wire logic         cin,
    output logic      [W-1:0] sum,
    output logic              carry,
    output logic              half
);

    logic [4:0]   lo;
    logic [W-4:0] hi;

    // ------------------------------------------------------------------
    // Split at the nibble so the digit carry needs no extra adder
    // ------------------------------------------------------------------
    always_comb begin
        lo    = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        hi    = {1'b0, a[W-1:4]} + {1'b0, b[W-1:4]} + {{(W-4){1'b0}}, lo[4]};
        sum   = {hi[W-5:0], lo[3:0]};
        carry = hi[W-4];                                   // [RL12]
        half  = lo[4];                                     // [RL12]
    end

endmodule : aasao_add8

/* File: hdl/aasao_ptr_add.sv */
/*
 * Pointer pair adder: sign-extends a short literal onto a wide pointer.
 * Purely combinational; the result wraps at the pointer width.
 */
`timescale 1ns/1ps
module aasao_ptr_add #(
    parameter int PW = 16,
    parameter int KW = 6
) (
    input  wire logic [PW-1:0] ptr,
    input  wire logic [KW-1:0] k,
    output logic      [PW-1:0] sum
);

    // ------------------------------------------------------------------
    // Carry out of the top bit is dropped, so the pointer wraps
    // ------------------------------------------------------------------
    always_comb begin
        sum = ptr + {{(PW-KW){k[KW-1]}}, k};               // [RL1] [RL2]
    end

endmodule : aasao_ptr_add

/* File: hdl/aasao_exec.sv */
/*
 * Accumulator datapath behind an AXI4-Lite slave: a write to the
 * instruction register executes one instruction in the same cycle.
 * Assumes a single AXI4-Lite master on aclk with synchronous reset.
 */
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module aasao_exec
    import aasao_pkg::*;
#(
    parameter int DATA_ADDR_W = 7
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    localparam int DMEM_DEPTH = 2 ** DATA_ADDR_W;

    // ------------------------------------------------------------------
    // Architectural state
    // ------------------------------------------------------------------
    logic [7:0]              dmem [DMEM_DEPTH];
    logic [13:0]             instr;
    logic [7:0]              accum;
    logic [3:0]              status;
    logic [15:0]             ptr0;
    logic [15:0]             ptr1;

    // ------------------------------------------------------------------
    // Bus side signals
    // ------------------------------------------------------------------
    logic                    aw_held;
    logic                    w_held;
    logic                    next_aw_held;
    logic                    next_w_held;
    logic [ADDR_W-1:0]       waddr_q;
    logic [31:0]             wdata_q;
    logic [3:0]              wstrb_q;
    logic                    do_write;
    logic [32:0]             wmap;
    logic [32:0]             rmap;
    logic [31:0]             wmask;
    logic [31:0]             wnew;
    logic                    sw_wr;

    // ------------------------------------------------------------------
    // Execute side signals
    // ------------------------------------------------------------------
    logic                    exec;
    aasao_op_e               ex_op;
    logic [DATA_ADDR_W-1:0]  ex_fa;
    logic [7:0]              ex_f;
    logic [7:0]              ex_k8;
    logic                    ex_d;
    logic                    ex_n;
    logic [5:0]              ex_k6;
    logic [7:0]              add_b;
    logic                    add_cin;
    logic [7:0]              add_sum;
    logic                    add_c;
    logic                    add_dc;
    logic [15:0]             ptr_sel;
    logic [15:0]             ptr_sum;
    logic [7:0]              res;
    logic                    res_to_acc;
    logic                    res_to_reg;
    logic [3:0]              next_status;

    // ------------------------------------------------------------------
    // Address map lookup, shared by the read and the write path
    // ------------------------------------------------------------------
    function automatic logic [32:0] map_word(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] aw;
        aw = {a[ADDR_W-1:2], 2'b00};
        map_word = {1'b1, 32'h0000_0000};
        if (aw[ADDR_W-1:DMEM_LSB] == OFS_DMEM[ADDR_W-1:DMEM_LSB]) begin
            map_word[31:0] = {24'h00_0000, dmem[aw[DATA_ADDR_W+1:2]]};
        end else begin
            case (aw)
                OFS_INSTR:  map_word[31:0] = {18'h0_0000, instr};
                OFS_ACCUM:  map_word[31:0] = {24'h00_0000, accum};
                OFS_STATUS: map_word[31:0] = {28'h000_0000, status};
                OFS_PTR0:   map_word[31:0] = {16'h0000, ptr0};
                OFS_PTR1:   map_word[31:0] = {16'h0000, ptr1};
                default:    map_word = 33'h0_0000_0000;
            endcase
        end
    endfunction : map_word

    // ------------------------------------------------------------------
    // Write channels: address and data are taken in either order
    // ------------------------------------------------------------------
    always_comb begin
        do_write     = aw_held && w_held && !s_axi_bvalid;
        next_aw_held = do_write ? 1'b0
                     : (aw_held || (s_axi_awvalid && s_axi_awready));
        next_w_held  = do_write ? 1'b0
                     : (w_held || (s_axi_wvalid && s_axi_wready));
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            aw_held       <= next_aw_held;
            w_held        <= next_w_held;
            s_axi_awready <= !next_aw_held;
            s_axi_wready  <= !next_w_held;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            waddr_q <= 12'h000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                waddr_q <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
        end
    end

    // Strobes merge new bytes into the current word of the target
    always_comb begin
        wmap  = map_word(waddr_q);
        wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                 {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
        wnew  = (wmap[31:0] & ~wmask) | (wdata_q & wmask);
        sw_wr = do_write && wmap[32];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wmap[32] ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Read channel: one outstanding read, answered at the taking edge
    // ------------------------------------------------------------------
    always_comb begin
        rmap = map_word(s_axi_araddr);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rmap[31:0];
            s_axi_rresp   <= rmap[32] ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Decode: the instruction word executes on the cycle it is written
    // ------------------------------------------------------------------
    always_comb begin
        exec  = sw_wr && (waddr_q == OFS_INSTR);           // [RL11]
        ex_fa = wnew[DATA_ADDR_W-1:0];                     // [RL13]
        ex_f  = dmem[ex_fa];
        ex_k8 = wnew[7:0];
        ex_d  = wnew[7];
        ex_n  = wnew[6];
        ex_k6 = wnew[5:0];
        ex_op = OPK_NONE;
        if (wnew[13:7] == OP_PTR) begin
            ex_op = OPK_PTR;                               // [RL11]
        end else begin
            case (wnew[13:8])
                OP_ADDI: ex_op = OPK_ADDI;
                OP_ANDI: ex_op = OPK_ANDI;
                OP_ANDR: ex_op = OPK_ANDR;
                OP_ADDR: ex_op = OPK_ADDR;
                OP_ASR:  ex_op = OPK_ASR;
                OP_ADDC: ex_op = OPK_ADDC;
                default: ex_op = OPK_NONE;
            endcase
        end
    end

    // One adder serves every byte add; the carry-in only for add with carry
    always_comb begin
        add_b   = (ex_op == OPK_ADDI) ? ex_k8 : ex_f;
        add_cin = (ex_op == OPK_ADDC) ? status[ST_C] : 1'b0; // [RL10]
        ptr_sel = ex_n ? ptr1 : ptr0;                      // [RL1]
    end

    aasao_add8 #(
        .W     (8)
    ) u_add (
        .a     (accum),
        .b     (add_b),
        .cin   (add_cin),
        .sum   (add_sum),
        .carry (add_c),
        .half  (add_dc)
    );

    aasao_ptr_add #(
        .PW  (16),
        .KW  (6)
    ) u_ptr (
        .ptr (ptr_sel),
        .k   (ex_k6),
        .sum (ptr_sum)
    );

    // ------------------------------------------------------------------
    // Result routing and flag update
    // ------------------------------------------------------------------
    always_comb begin
        res         = 8'h00;
        res_to_acc  = 1'b0;
        res_to_reg  = 1'b0;
        next_status = status;
        unique case (ex_op)
            OPK_ADDI: begin
                res        = add_sum;                      // [RL4]
                res_to_acc = 1'b1;
                next_status[ST_C]  = add_c;
                next_status[ST_DC] = add_dc;
            end
            OPK_ANDI: begin
                res        = accum & ex_k8;                // [RL3]
                res_to_acc = 1'b1;
            end
            OPK_ANDR: begin
                res = accum & ex_f;                        // [RL5]
            end
            OPK_ADDR, OPK_ADDC: begin
                res = add_sum;                             // [RL7] [RL10]
                next_status[ST_C]  = add_c;
                next_status[ST_DC] = add_dc;
            end
            OPK_ASR: begin
                res = {ex_f[7], ex_f[7:1]};                // [RL8] [RL9]
                next_status[ST_C] = ex_f[0];               // [RL8]
            end
            OPK_PTR: begin
                res = 8'h00;                               // [RL13]
            end
            OPK_NONE: begin
                next_status[ST_UNK] = 1'b1;
            end
        endcase
        if (ex_op != OPK_PTR && ex_op != OPK_NONE) begin
            next_status[ST_Z] = (res == 8'h00);            // [RL12]
        end
        if (ex_op == OPK_ANDR || ex_op == OPK_ADDR
            || ex_op == OPK_ADDC || ex_op == OPK_ASR) begin
            res_to_acc = !ex_d;                            // [RL6]
            res_to_reg = ex_d;                             // [RL6]
        end
    end

    // ------------------------------------------------------------------
    // State updates: a bus write to another register and an execution never share a cycle
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            instr <= RST_INSTR;
        end else if (exec) begin
            instr <= wnew[13:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            accum <= RST_ACCUM;
        end else if (exec && res_to_acc) begin
            accum <= res;
        end else if (sw_wr && waddr_q == OFS_ACCUM) begin
            accum <= wnew[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status <= RST_STATUS;
        end else if (exec) begin
            status <= next_status;
        end else if (sw_wr && waddr_q == OFS_STATUS) begin
            status <= wnew[3:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ptr0 <= RST_PTR;
            ptr1 <= RST_PTR;
        end else if (exec && ex_op == OPK_PTR) begin
            if (ex_n) begin
                ptr1 <= ptr_sum;                           // [RL1] [RL2]
            end else begin
                ptr0 <= ptr_sum;                           // [RL1] [RL2]
            end
        end else if (sw_wr && waddr_q == OFS_PTR0) begin
            ptr0 <= wnew[15:0];
        end else if (sw_wr && waddr_q == OFS_PTR1) begin
            ptr1 <= wnew[15:0];
        end
    end

    // Data memory holds no reset; software loads it before use
    always_ff @(posedge aclk) begin
        if (exec && res_to_reg) begin
            dmem[ex_fa] <= res;                            // [RL6]
        end else if (sw_wr && waddr_q[ADDR_W-1:DMEM_LSB]
                     == OFS_DMEM[ADDR_W-1:DMEM_LSB]) begin
            dmem[waddr_q[DATA_ADDR_W+1:2]] <= wnew[7:0];
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_PTR_ADD: assert property ( // [RL1]
        exec && ex_op == OPK_PTR && !ex_n
        |=> ptr0 == 16'($past(ptr0) + {{10{$past(ex_k6[5])}},
                                         $past(ex_k6)}) && $stable(ptr1))
        else $error("pointer add result wrong");

    AST_PTR_WRAP: assert property ( // [RL2]
        exec && ex_op == OPK_PTR && ex_n && ptr1 == 16'hffff
        && ex_k6 == 6'h01 |=> ptr1 == 16'h0000)
        else $error("pointer did not wrap");

    AST_AND_IMM: assert property ( // [RL3]
        exec && ex_op == OPK_ANDI
        |=> accum == ($past(accum) & $past(ex_k8))
            && status[ST_C] == $past(status[ST_C])
            && status[ST_DC] == $past(status[ST_DC]))
        else $error("and with immediate wrong");

    AST_ADD_IMM: assert property ( // [RL4]
        exec && ex_op == OPK_ADDI
        |=> {status[ST_C], accum}
            == ({1'b0, $past(accum)} + {1'b0, $past(ex_k8)}))
        else $error("add with immediate wrong");

    AST_AND_REG: assert property ( // [RL5]
        exec && ex_op == OPK_ANDR && ex_d
        |=> dmem[$past(ex_fa)] == ($past(accum) & $past(ex_f))
            && $stable(accum))
        else $error("and with register wrong");

    AST_DEST_ACC: assert property ( // [RL6]
        exec && ex_op == OPK_ADDR && !ex_d
        |=> dmem[$past(ex_fa)] == $past(ex_f))
        else $error("register written with destination 0");

    AST_ADD_REG: assert property ( // [RL7]
        exec && ex_op == OPK_ADDR && !ex_d
        |=> {status[ST_C], accum}
            == ({1'b0, $past(accum)} + {1'b0, $past(ex_f)}))
        else $error("add with register wrong");

    AST_ASR_CARRY: assert property ( // [RL8]
        exec && ex_op == OPK_ASR && !ex_d
        |=> status[ST_C] == $past(ex_f[0])
            && accum[6:0] == $past(ex_f[7:1]))
        else $error("shift carry or bits wrong");

    AST_ASR_SIGN: assert property ( // [RL9]
        exec && ex_op == OPK_ASR && !ex_d
        |=> accum[7] == $past(ex_f[7]))
        else $error("shift lost the sign bit");

    AST_ADD_CARRY: assert property ( // [RL10]
        exec && ex_op == OPK_ADDC && !ex_d
        |=> {status[ST_C], accum} == ({1'b0, $past(accum)}
            + {1'b0, $past(ex_f)} + {8'h00, $past(status[ST_C])}))
        else $error("add with carry wrong");

    AST_ZERO_DC: assert property ( // [RL12]
        exec && ex_op == OPK_ADDI
        |=> status[ST_Z] == (accum == 8'h00)
            && status[ST_DC] == (({1'b0, $past(accum[3:0])}
                + {1'b0, $past(ex_k8[3:0])}) > 5'h0f))
        else $error("zero or digit carry wrong");

    AST_PTR_FLAGS: assert property ( // [RL13]
        exec && ex_op == OPK_PTR |=> $stable(status) && $stable(accum))
        else $error("pointer add touched flags");

endmodule : aasao_exec

/* File: bench/aasao_exec_tb.sv */
/*
 * Self-checking bench: runs each instruction class over AXI4-Lite.
 * Assumes the package and design modules are compiled before it.
 */
`timescale 1ns/1ps
module aasao_exec_tb import aasao_pkg::*;;

    // ------------------------------------------------------------
    // Signals and design
    // ------------------------------------------------------------
    logic              aclk = 1'h0, aresetn = 1'h0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [31:0]       wdata = '0, rdata;
    logic [1:0]        bresp, rresp;
    logic              awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic              arvalid = 1'h0, rready = 1'h0;
    logic              awready, wready, bvalid, arready, rvalid;
    int                n_mismatch = 0, cmp_count = 0;

    aasao_exec i_aasao_exec (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    always #5 aclk = ~aclk;

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic close_out;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Bounded wait: a hung handshake ends the run as a failure
    task automatic tick(inout int n);
        @(posedge aclk);
        n++;
        if (n > 40) begin
            chk("timeout", 32'h0, 32'h1);
            close_out();
        end
    endtask : tick

    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                          input logic [1:0] er = RESP_OKAY);
        int   n = 0;
        logic done = 1'h0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!done) begin
            tick(n);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid === 1'h1) begin
                chk("bresp", {30'h0, er}, {30'h0, bresp});
                bready <= 1'h0;
                done = 1'h1;
            end
        end
    endtask : axi_wr

    task automatic rc(input logic [11:0] a, input logic [31:0] e,
                      input string nm, input logic [1:0] er = RESP_OKAY);
        int   n = 0;
        logic done = 1'h0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        while (!done) begin
            tick(n);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid === 1'h1) begin
                chk(nm, e, rdata);
                chk("rresp", {30'h0, er}, {30'h0, rresp});
                rready <= 1'h0;
                done = 1'h1;
            end
        end
    endtask : rc

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_imm;
        rc(OFS_STATUS, 32'h0, "status");
        axi_wr(OFS_ACCUM, 32'h0f);
        axi_wr(OFS_INSTR, 32'h3e01);
        rc(OFS_ACCUM, 32'h10, "accum");
        rc(OFS_STATUS, 32'h2, "status");
        axi_wr(OFS_INSTR, 32'h3ef0);
        rc(OFS_ACCUM, 32'h0, "accum");
        rc(OFS_STATUS, 32'h5, "status");
        axi_wr(OFS_ACCUM, 32'ha5);
        axi_wr(OFS_STATUS, 32'h3);
        axi_wr(OFS_INSTR, 32'h395a);
        rc(OFS_ACCUM, 32'h0, "accum");
        rc(OFS_STATUS, 32'h7, "status");
    endtask : t_imm

    task automatic t_reg;
        axi_wr(OFS_DMEM + 12'h1fc, 32'h3c);
        axi_wr(OFS_ACCUM, 32'h0f);
        axi_wr(OFS_STATUS, 32'h3);
        axi_wr(OFS_INSTR, 32'h05ff);
        rc(OFS_DMEM + 12'h1fc, 32'h0c, "dmem127");
        rc(OFS_ACCUM, 32'h0f, "accum");
        rc(OFS_STATUS, 32'h3, "status");
        axi_wr(OFS_DMEM + 12'h014, 32'h88);
        axi_wr(OFS_ACCUM, 32'h88);
        axi_wr(OFS_STATUS, 32'h4);
        axi_wr(OFS_INSTR, 32'h0705);
        rc(OFS_ACCUM, 32'h10, "accum");
        rc(OFS_STATUS, 32'h3, "status");
        rc(OFS_DMEM + 12'h014, 32'h88, "dmem5");
    endtask : t_reg

    task automatic t_shift_carry;
        axi_wr(OFS_DMEM + 12'h00c, 32'h81);
        axi_wr(OFS_STATUS, 32'h6);
        axi_wr(OFS_INSTR, 32'h3703);
        rc(OFS_ACCUM, 32'hc0, "accum");
        rc(OFS_STATUS, 32'h3, "status");
        axi_wr(OFS_DMEM + 12'h010, 32'h01);
        axi_wr(OFS_INSTR, 32'h3784);
        rc(OFS_DMEM + 12'h010, 32'h0, "dmem4");
        rc(OFS_STATUS, 32'h7, "status");
        axi_wr(OFS_DMEM + 12'h008, 32'h08);
        axi_wr(OFS_ACCUM, 32'h07);
        axi_wr(OFS_STATUS, 32'h1);
        axi_wr(OFS_INSTR, 32'h3d82);
        rc(OFS_DMEM + 12'h008, 32'h10, "dmem2");
        rc(OFS_STATUS, 32'h2, "status");
        axi_wr(OFS_STATUS, 32'h1);
        axi_wr(OFS_INSTR, 32'h3d02);
        rc(OFS_ACCUM, 32'h18, "accum");
        rc(OFS_STATUS, 32'h0, "status");
    endtask : t_shift_carry

    // Both wrap directions and both literal extremes
    task automatic t_ptr;
        axi_wr(OFS_PTR0, 32'hffff);
        axi_wr(OFS_STATUS, 32'h7);
        axi_wr(OFS_ACCUM, 32'h55);
        axi_wr(OFS_INSTR, 32'h3101);
        rc(OFS_PTR0, 32'h0, "ptr0");
        axi_wr(OFS_INSTR, 32'h3160);
        rc(OFS_PTR1, 32'hffe0, "ptr1");
        axi_wr(OFS_PTR1, 32'hffff);
        axi_wr(OFS_INSTR, 32'h3141);
        rc(OFS_PTR1, 32'h0, "ptr1");
        axi_wr(OFS_INSTR, 32'h311f);
        rc(OFS_PTR0, 32'h1f, "ptr0");
        rc(OFS_INSTR, 32'h311f, "instr");
        rc(OFS_STATUS, 32'h7, "status");
        rc(OFS_ACCUM, 32'h55, "accum");
        axi_wr(12'h014, 32'h1, RESP_SLVERR);
        rc(12'h014, 32'h0, "unmapped", RESP_SLVERR);
        // Unknown opcode sets only the spare status bit
        axi_wr(OFS_INSTR, 32'h0);
        rc(OFS_STATUS, 32'hf, "status");
    endtask : t_ptr

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        t_imm();
        t_reg();
        t_shift_carry();
        t_ptr();
        close_out();
    end

endmodule : aasao_exec_tb
